// [src/oltc_pkg.sv]
package oltc_pkg;
    localparam logic [11:0] ADDR_CMD = 12'h000;
    localparam logic [11:0] ADDR_RESULT = 12'h004;
    localparam logic [11:0] ADDR_POOL = 12'h100;
    localparam int POOL_BYTES = 128;
    localparam int POOL_WORDS = 32;
    localparam int DOORBELL_BIT = 15;
    localparam logic [15:0] CMD_READ_BUF = 16'h8209;
    localparam logic [15:0] CMD_LAYER_EN = 16'h820a;
    localparam logic [15:0] CMD_LAYER_STAT = 16'h820b;
    localparam logic [15:0] CMD_SET_STR0 = 16'h820c;
    localparam logic [15:0] CMD_SET_STR1 = 16'h820f;
    localparam logic [15:0] CMD_SET_STR2 = 16'h8210;
    localparam logic [15:0] CMD_SET_STR3 = 16'h8211;
    localparam logic [15:0] CMD_GET_STR0 = 16'h820d;
    localparam logic [15:0] CMD_GET_STR1 = 16'h8212;
    localparam logic [15:0] CMD_GET_STR2 = 16'h8213;
    localparam logic [15:0] CMD_GET_STR3 = 16'h8214;
    localparam int LE_OFF_LAYER = 0;
    localparam int LE_OFF_OVL = 1;
    localparam int LE_OFF_EN = 2;
    localparam int LS_OFF_EN = 0;
    localparam int LS_OFF_OVL = 1;
    localparam int LS_OFF_ERR = 2;
    localparam int RB_OFF_OVL = 0;
    localparam int RB_OFF_LEN = 1;
    localparam int RB_OFF_OFS = 2;
    localparam int STR_OFF_GLYPH = 8;
    localparam int STR_BYTES = 72;
    localparam int NUM_LAYERS = 11;
    localparam logic [7:0] MAX_INDEX = 8'h0a;
    localparam logic [7:0] MAX_BITMAP_OVL = 8'h06;
    localparam int NUM_BITMAP_OVL = 7;
    localparam int NUM_STR = 4;
    localparam int STR_POS = 64;
    localparam logic [7:0] USER_GLYPH_BASE = 8'hc0;
    localparam logic [7:0] SUCCESS_CODE = 8'h00;
    localparam logic [7:0] NOT_FOUND_CODE = 8'h01;
    localparam logic [7:0] ALREADY_CODE = 8'h02;
    localparam logic [7:0] INVALID_ARGUMENT_CODE = 8'h03;
    localparam logic [7:0] BUSY_CODE = 8'h04;
    localparam logic [7:0] RESULT_RESET = 8'h00;

    typedef struct packed {
        logic en;
        logic [3:0] ovl;
    } oltc_layer_t;

    typedef enum {OLTC_IDLE, OLTC_EXEC, OLTC_RD_ADDR, OLTC_RD_CAP} oltc_state_t;
endpackage

// [src/oltc_top.sv]
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - Buffer read is refused while its overlay is shown on an enabled layer.
// - Buffer read is refused while any buffer load is in progress.
// - Buffer read returns run-length data only, never configuration data.
// - Layer enable command 0x820A takes layer, overlay and enable bytes.
// - Enabling an empty bitmap overlay answers not found.
// - Disabling an already disabled layer answers already.
// - Bad overlay answers invalid argument; busy device answers busy.
// - Layer changes are accepted whenever no load is in progress and reach hardware during blanking.
// - Reissuing enable with another overlay switches it without disabling first.
// - Two layers never show the same overlay; the older user is disabled.
// - Layer status query 0x820B takes one layer byte; bad layer is invalid.
// - Status answer holds enabled flag and, if enabled, the overlay index.
// - Status answer holds a hardware error byte at offset two.
// - String set codes 0x820C, 0x820F, 0x8210, 0x8211 select strings 0 to 3.
// - Four 16-bit masks then 64 glyph index bytes from offset eight.
// - Each string has 64 positions each with its own enable bit.
// - Index 0 to 191 is font ROM, 192 to 255 is user character memory.
// - String set always replaces the whole string, applied during blanking.
// - String set answers busy during a load, otherwise success.
// - String get codes 0x820D, 0x8212 to 0x8214 return the set layout.
// - String get answers busy while a load is incomplete.
// - Refused buffer read answers already, or busy during a load, and reads nothing.
// - Buffer read 0x8209 places data bytes in the pool from offset zero.
module oltc_top
    import oltc_pkg::*;
#(
    parameter int BUF_BYTES = 4096
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frame_blank,
    input wire logic load_busy,
    input wire logic [NUM_BITMAP_OVL-1:0] overlay_empty,
    input wire logic [7:0] hw_error,
    output logic buf_rd_en,
    output logic [3:0] buf_rd_ovl,
    output logic [15:0] buf_rd_addr,
    input wire logic [7:0] buf_rd_data,
    output oltc_layer_t [NUM_LAYERS-1:0] layer_out,
    input wire logic [1:0] disp_str_sel,
    input wire logic [5:0] disp_pos,
    output logic disp_pos_en,
    output logic [7:0] disp_glyph,
    output logic disp_glyph_user
);

    ////////////////////////////////////////////////////////////////////////////
    oltc_state_t state_reg;
    logic [15:0] cmd_reg;
    logic [7:0] result_reg;
    logic [7:0] pool_mem [POOL_BYTES];
    oltc_layer_t [NUM_LAYERS-1:0] pend_layer;
    logic [STR_POS-1:0] pend_mask [NUM_STR];
    logic [7:0] pend_glyph [NUM_STR][STR_POS];
    logic [STR_POS-1:0] act_mask [NUM_STR];
    logic [7:0] act_glyph [NUM_STR][STR_POS];
    logic [7:0] rd_len_reg;
    logic [7:0] rd_cnt_reg;
    logic [15:0] rd_ofs_reg;
    logic [3:0] rd_ovl_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic apb_setup;
    logic apb_access;
    logic pool_hit;
    logic [4:0] pool_word;
    logic cmd_start;
    logic [7:0] arg0;
    logic [7:0] arg1;
    logic [7:0] arg2;
    logic [15:0] rb_ofs;
    logic ovl_in_use;
    logic [1:0] str_idx;
    logic is_set;
    logic is_get;
    logic [7:0] exec_res;
    logic le_commit;
    logic ls_write;
    logic rb_go;
    assign apb_setup = psel && !penable;
    assign apb_access = psel && penable;
    assign pool_hit = (paddr >= ADDR_POOL) && (paddr < ADDR_POOL + 12'(POOL_BYTES));
    assign pool_word = paddr[6:2];
    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    // A new command is only taken while idle, so the pool cannot change under a running one.
    assign cmd_start = apb_access && pwrite && (paddr == ADDR_CMD) && (state_reg == OLTC_IDLE)
        && pwdata[DOORBELL_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Read data and the error answer are prepared in the setup cycle and held for the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (apb_setup) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
            if (paddr == ADDR_CMD) begin
                prdata_reg <= {16'h0000, (state_reg != OLTC_IDLE), cmd_reg[14:0]};
                pslverr_reg <= pwrite && (state_reg != OLTC_IDLE);
            end else if (paddr == ADDR_RESULT) begin
                prdata_reg <= {24'h00_0000, result_reg};
                pslverr_reg <= pwrite;
            end else if (pool_hit) begin
                prdata_reg <= {pool_mem[{pool_word, 2'd0}], pool_mem[{pool_word, 2'd1}],
                    pool_mem[{pool_word, 2'd2}], pool_mem[{pool_word, 2'd3}]};
                pslverr_reg <= pwrite && (state_reg != OLTC_IDLE);
            end else begin
                pslverr_reg <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign arg0 = pool_mem[0];
    assign arg1 = pool_mem[1];
    assign arg2 = pool_mem[2];
    assign rb_ofs = {pool_mem[RB_OFF_OFS], pool_mem[RB_OFF_OFS+1]};
    always_comb begin
        ovl_in_use = 1'b0;
        for (int i = 0; i < NUM_LAYERS; i++) begin
            if (pend_layer[i].en && ({4'h0, pend_layer[i].ovl} == arg0)) begin
                ovl_in_use = 1'b1;
            end
        end
    end
    always_comb begin
        str_idx = 2'd0;
        is_set = 1'b0;
        is_get = 1'b0;
        exec_res = SUCCESS_CODE;
        le_commit = 1'b0;
        ls_write = 1'b0;
        rb_go = 1'b0;
        case (cmd_reg)
            CMD_SET_STR0: begin is_set = 1'b1; str_idx = 2'd0; end
            CMD_SET_STR1: begin is_set = 1'b1; str_idx = 2'd1; end
            CMD_SET_STR2: begin is_set = 1'b1; str_idx = 2'd2; end
            CMD_SET_STR3: begin is_set = 1'b1; str_idx = 2'd3; end
            CMD_GET_STR0: begin is_get = 1'b1; str_idx = 2'd0; end
            CMD_GET_STR1: begin is_get = 1'b1; str_idx = 2'd1; end
            CMD_GET_STR2: begin is_get = 1'b1; str_idx = 2'd2; end
            CMD_GET_STR3: begin is_get = 1'b1; str_idx = 2'd3; end
            default: begin end
        endcase
        if (state_reg == OLTC_EXEC) begin
            case (cmd_reg)
                CMD_LAYER_EN: begin
                    if (load_busy) exec_res = BUSY_CODE;
                    else if (arg0 > MAX_INDEX || arg1 > MAX_INDEX) exec_res = INVALID_ARGUMENT_CODE;
                    else if (arg2 != 8'h00 && arg1 <= MAX_BITMAP_OVL && overlay_empty[arg1[2:0]])
                        exec_res = NOT_FOUND_CODE;
                    else if (arg2 == 8'h00 && !pend_layer[arg0[3:0]].en) exec_res = ALREADY_CODE;
                    else le_commit = 1'b1;
                end
                CMD_LAYER_STAT: begin
                    if (arg0 > MAX_INDEX) exec_res = INVALID_ARGUMENT_CODE;
                    else ls_write = 1'b1;
                end
                CMD_READ_BUF: begin
                    if (load_busy) exec_res = BUSY_CODE;
                    else if (arg0 > MAX_BITMAP_OVL) exec_res = INVALID_ARGUMENT_CODE;
                    else if (ovl_in_use) exec_res = ALREADY_CODE;
                    else if (arg1 > 8'(POOL_BYTES - 1) || 17'(rb_ofs) + 17'(arg1) > 17'(BUF_BYTES))
                        exec_res = INVALID_ARGUMENT_CODE;
                    else rb_go = 1'b1;
                end
                default: begin
                    if ((is_set || is_get) && load_busy) exec_res = BUSY_CODE;
                    else if (!(is_set || is_get)) exec_res = INVALID_ARGUMENT_CODE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The result lands on the same edge that drops the busy flag, so a poller never sees a stale code.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= OLTC_IDLE;
            cmd_reg <= 16'h0000;
            result_reg <= RESULT_RESET;
            rd_len_reg <= 8'h00;
            rd_cnt_reg <= 8'h00;
            rd_ofs_reg <= 16'h0000;
            rd_ovl_reg <= 4'h0;
        end else begin
            case (state_reg)
                OLTC_IDLE: begin
                    if (cmd_start) begin
                        cmd_reg <= pwdata[15:0];
                        state_reg <= OLTC_EXEC;
                    end
                end
                OLTC_EXEC: begin
                    if (rb_go) begin
                        rd_len_reg <= arg1;
                        rd_ofs_reg <= rb_ofs;
                        rd_ovl_reg <= pool_mem[RB_OFF_OVL][3:0];
                        rd_cnt_reg <= 8'h00;
                        state_reg <= OLTC_RD_ADDR;
                    end else begin
                        result_reg <= exec_res;
                        state_reg <= OLTC_IDLE;
                    end
                end
                OLTC_RD_ADDR: begin
                    if (rd_cnt_reg == rd_len_reg) begin
                        result_reg <= SUCCESS_CODE;
                        state_reg <= OLTC_IDLE;
                    end else begin
                        state_reg <= OLTC_RD_CAP;
                    end
                end
                OLTC_RD_CAP: begin
                    rd_cnt_reg <= rd_cnt_reg + 8'h01;
                    state_reg <= OLTC_RD_ADDR;
                end
                default: state_reg <= OLTC_IDLE;
            endcase
        end
    end
    // Only the run-length region of a buffer is addressed here; configuration lives elsewhere.
    assign buf_rd_en = (state_reg == OLTC_RD_ADDR) && (rd_cnt_reg != rd_len_reg);
    assign buf_rd_ovl = rd_ovl_reg;
    assign buf_rd_addr = rd_ofs_reg + 16'(rd_cnt_reg);
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int b = 0; b < POOL_BYTES; b++) pool_mem[b] <= 8'h00;
        end else if (cmd_start || (apb_access && pwrite && pool_hit && state_reg == OLTC_IDLE)) begin
            if (!cmd_start) begin
                for (int k = 0; k < 4; k++) begin
                    if (pstrb[k]) pool_mem[{pool_word, 2'(3 - k)}] <= pwdata[8*k +: 8];
                end
            end
        end else if (ls_write) begin
            pool_mem[LS_OFF_EN] <= {7'h00, pend_layer[arg0[3:0]].en};
            pool_mem[LS_OFF_OVL] <= pend_layer[arg0[3:0]].en ? {4'h0, pend_layer[arg0[3:0]].ovl} : 8'h00;
            pool_mem[LS_OFF_ERR] <= hw_error;
        end else if (state_reg == OLTC_EXEC && is_get && !load_busy) begin
            for (int m = 0; m < 4; m++) begin
                pool_mem[2*m] <= pend_mask[str_idx][16*m+8 +: 8];
                pool_mem[2*m+1] <= pend_mask[str_idx][16*m +: 8];
            end
            for (int p = 0; p < STR_POS; p++) pool_mem[STR_OFF_GLYPH+p] <= pend_glyph[str_idx][p];
        end else if (state_reg == OLTC_RD_CAP) begin
            pool_mem[rd_cnt_reg[6:0]] <= buf_rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Commands edit the pending set; the display copy only moves during blanking.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_layer <= '0;
        end else if (le_commit) begin
            for (int i = 0; i < NUM_LAYERS; i++) begin
                if (i != int'(arg0) && arg2 != 8'h00 && pend_layer[i].en && pend_layer[i].ovl == arg1[3:0])
                    pend_layer[i].en <= 1'b0;
            end
            pend_layer[arg0[3:0]].en <= (arg2 != 8'h00);
            if (arg2 != 8'h00) pend_layer[arg0[3:0]].ovl <= arg1[3:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int s = 0; s < NUM_STR; s++) begin
                pend_mask[s] <= '0;
                for (int p = 0; p < STR_POS; p++) pend_glyph[s][p] <= 8'h00;
            end
        end else if (state_reg == OLTC_EXEC && is_set && !load_busy) begin
            for (int m = 0; m < 4; m++) begin
                pend_mask[str_idx][16*m +: 16] <= {pool_mem[2*m], pool_mem[2*m+1]};
            end
            for (int p = 0; p < STR_POS; p++) pend_glyph[str_idx][p] <= pool_mem[STR_OFF_GLYPH+p];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            layer_out <= '0;
            for (int s = 0; s < NUM_STR; s++) begin
                act_mask[s] <= '0;
                for (int p = 0; p < STR_POS; p++) act_glyph[s][p] <= 8'h00;
            end
        end else if (frame_blank) begin
            layer_out <= pend_layer;
            act_mask <= pend_mask;
            act_glyph <= pend_glyph;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_pos_en <= 1'b0;
            disp_glyph <= 8'h00;
            disp_glyph_user <= 1'b0;
        end else begin
            disp_pos_en <= act_mask[disp_str_sel][disp_pos];
            disp_glyph <= act_glyph[disp_str_sel][disp_pos];
            disp_glyph_user <= act_glyph[disp_str_sel][disp_pos] >= USER_GLYPH_BASE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic dup_ovl(oltc_layer_t [NUM_LAYERS-1:0] l);
        logic d;
        d = 1'b0;
        for (int i = 0; i < NUM_LAYERS; i++)
            for (int j = i + 1; j < NUM_LAYERS; j++)
                if (l[i].en && l[j].en && l[i].ovl == l[j].ovl) d = 1'b1;
        return d;
    endfunction
    logic exec_rb;
    logic exec_le;
    assign exec_rb = state_reg == OLTC_EXEC && cmd_reg == CMD_READ_BUF;
    assign exec_le = state_reg == OLTC_EXEC && cmd_reg == CMD_LAYER_EN;
    rb_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
        exec_rb && !load_busy && arg0 <= MAX_BITMAP_OVL && ovl_in_use
        |=> result_reg == ALREADY_CODE && state_reg == OLTC_IDLE && !buf_rd_en)
        else $error("buffer read of shown overlay not refused");
    rb_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
        exec_rb && load_busy |=> result_reg == BUSY_CODE ##1 !buf_rd_en)
        else $error("buffer read ran during a load");
    le_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
        exec_le && load_busy |=> result_reg == BUSY_CODE && $stable(pend_layer))
        else $error("layer enable not busy during load");
    le_range_a: assert property (@(posedge pclk) disable iff (!presetn)
        exec_le && !load_busy && (arg0 > MAX_INDEX || arg1 > MAX_INDEX)
        |=> result_reg == INVALID_ARGUMENT_CODE && pend_layer == $past(pend_layer))
        else $error("out of range layer index accepted");
    blank_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
        !frame_blank |=> $stable(layer_out))
        else $error("layer output moved outside blanking");
    ovl_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
        !dup_ovl(pend_layer))
        else $error("two layers share one overlay");
    cmd_done_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == OLTC_EXEC && !rb_go |=> state_reg == OLTC_IDLE && result_reg == $past(exec_res))
        else $error("command finished without its result");
    str_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == OLTC_EXEC && is_set |=> result_reg == (($past(load_busy)) ? BUSY_CODE : SUCCESS_CODE))
        else $error("string set result wrong");
    stat_resp_a: assert property (@(posedge pclk) disable iff (!presetn)
        ls_write |=> pool_mem[LS_OFF_EN][0] == $past(pend_layer[arg0[3:0]].en) && pool_mem[LS_OFF_ERR] == $past(hw_error))
        else $error("layer status answer wrong");
    rb_done_c: cover property (@(posedge pclk) disable iff (!presetn)
        state_reg == OLTC_RD_CAP ##1 state_reg == OLTC_RD_ADDR ##1 state_reg == OLTC_IDLE);
    le_switch_c: cover property (@(posedge pclk) disable iff (!presetn) le_commit && pend_layer[arg0[3:0]].en);
    str_set_c: cover property (@(posedge pclk) disable iff (!presetn) state_reg == OLTC_EXEC && is_set && !load_busy);
endmodule // oltc_top

// [test/oltc_buf_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Bitmap buffer stand-in for the run-length region only.
// Outside a strobe the byte is inverted every cycle, so stale data looks valid again on every second cycle.
module oltc_buf_model
    import oltc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic buf_rd_en,
    input wire logic [3:0] buf_rd_ovl,
    input wire logic [15:0] buf_rd_addr,
    output logic [7:0] buf_rd_data
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_rd_data <= 8'h00;
        end else if (buf_rd_en) begin
            buf_rd_data <= buf_rd_addr[7:0] ^ {buf_rd_ovl, 4'h5};
        end else begin
            buf_rd_data <= ~buf_rd_data;
        end
    end
endmodule // oltc_buf_model

// [test/oltc_top_tb.sv]
`timescale 1ns/1ps
module oltc_top_tb
    import oltc_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic frame_blank = 1'b0;
    logic load_busy = 1'b0;
    logic [NUM_BITMAP_OVL-1:0] overlay_empty = '0;
    logic [7:0] hw_error = 8'h5a;
    logic buf_rd_en;
    logic [3:0] buf_rd_ovl;
    logic [15:0] buf_rd_addr;
    logic [7:0] buf_rd_data;
    oltc_layer_t [NUM_LAYERS-1:0] layer_out;
    logic [1:0] disp_str_sel = 2'h0;
    logic [5:0] disp_pos = 6'h00;
    logic disp_pos_en;
    logic [7:0] disp_glyph;
    logic disp_glyph_user;
    int err_count = 0;
    int n_checks = 0;
    logic [31:0] rv;
    logic rerr;
    logic [15:0] setc [4] = '{CMD_SET_STR0, CMD_SET_STR1, CMD_SET_STR2, CMD_SET_STR3};
    logic [15:0] getc [4] = '{CMD_GET_STR0, CMD_GET_STR1, CMD_GET_STR2, CMD_GET_STR3};
    logic [15:0] busyc [4] = '{CMD_LAYER_EN, CMD_SET_STR2, CMD_GET_STR3, CMD_READ_BUF};
    int pos [3] = '{0, 21, 63};

    always #50 pclk = ~pclk;

    oltc_top #(.BUF_BYTES(4096)) oltc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .frame_blank, .load_busy, .overlay_empty, .hw_error, .buf_rd_en,
        .buf_rd_ovl, .buf_rd_addr, .buf_rd_data, .layer_out, .disp_str_sel, .disp_pos, .disp_pos_en,
        .disp_glyph, .disp_glyph_user);
    oltc_buf_model oltc_buf_model_inst (.pclk, .presetn, .buf_rd_en, .buf_rd_ovl, .buf_rd_addr, .buf_rd_data);

    ////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // The request stays put until pready is seen; read data is taken at that edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rv = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmd(input logic [15:0] c, input logic [7:0] exp);
        apb(1'b1, ADDR_CMD, {16'h0, c});
        rv = 32'h8000;
        for (int i = 0; i < 300 && rv[15] !== 1'b0; i++) apb(1'b0, ADDR_CMD, 32'h0);
        apb(1'b0, ADDR_RESULT, 32'h0);
        chk(rv[7:0], exp);
    endtask
    task automatic le(input logic [31:0] w, input logic [15:0] c, input logic [7:0] exp);
        apb(1'b1, ADDR_POOL, w);
        cmd(c, exp);
    endtask
    task automatic stat(input logic [7:0] l, input logic [23:0] exp);
        le({l, 24'h0}, CMD_LAYER_STAT, SUCCESS_CODE);
        apb(1'b0, ADDR_POOL, 32'h0);
        chk(rv[31:8], exp);
    endtask
    task automatic blank;
        @(posedge pclk);
        frame_blank <= 1'b1;
        @(posedge pclk);
        frame_blank <= 1'b0;
        #1;
    endtask
    function automatic logic [7:0] pb(int s, int i);
        return 8'(i * 7 + s * 61 + 3);
    endfunction
    function automatic logic [31:0] pw(int s, int w);
        return {pb(s, 4 * w), pb(s, 4 * w + 1), pb(s, 4 * w + 2), pb(s, 4 * w + 3)};
    endfunction
    task automatic disp(int s, int p, logic live);
        logic [15:0] mk;
        logic [7:0] g;
        mk = {pb(s, 2 * (p / 16)), pb(s, 2 * (p / 16) + 1)};
        g = pb(s, 8 + p);
        @(posedge pclk);
        disp_str_sel <= 2'(s);
        disp_pos <= 6'(p);
        repeat (2) @(posedge pclk);
        #1;
        chk({disp_pos_en, disp_glyph_user, disp_glyph}, live ? {mk[p % 16], g >= USER_GLYPH_BASE, g} : 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////
    // The limit is far above the fewer than a thousand cycles the sequence needs.
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        le(32'h0003_0100, CMD_LAYER_EN, SUCCESS_CODE);
        chk(layer_out[0], 32'h0);
        blank();
        chk(layer_out[0], 32'h13);
        stat(8'd0, 24'h01035a);
        le(32'h0103_0100, CMD_LAYER_EN, SUCCESS_CODE);
        stat(8'd0, 24'h00005a);
        le(32'h0104_0100, CMD_LAYER_EN, SUCCESS_CODE);
        stat(8'd1, 24'h01045a);
        blank();
        chk({layer_out[1], layer_out[0].en}, 32'h28);
        le(32'h0200_0000, CMD_LAYER_EN, ALREADY_CODE);
        overlay_empty <= 7'h20;
        le(32'h0205_0100, CMD_LAYER_EN, NOT_FOUND_CODE);
        le(32'h0b03_0100, CMD_LAYER_EN, INVALID_ARGUMENT_CODE);
        le(32'h020b_0100, CMD_LAYER_EN, INVALID_ARGUMENT_CODE);
        le(32'h0b00_0000, CMD_LAYER_STAT, INVALID_ARGUMENT_CODE);
        stat(8'd1, 24'h01045a);
        le(32'h0404_0010, CMD_READ_BUF, ALREADY_CODE);
        apb(1'b0, ADDR_POOL, 32'h0);
        chk(rv, 32'h0404_0010);
        le(32'h0204_0010, CMD_READ_BUF, SUCCESS_CODE);
        apb(1'b0, ADDR_POOL, 32'h0);
        chk(rv, 32'h3534_3736);
        load_busy <= 1'b1;
        for (int i = 0; i < 4; i++) cmd(busyc[i], BUSY_CODE);
        load_busy <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            for (int w = 0; w < 18; w++) apb(1'b1, ADDR_POOL + 12'(4 * w), pw(s, w));
            cmd(setc[s], SUCCESS_CODE);
        end
        disp(0, 63, 1'b0);
        for (int s = 0; s < 4; s++) begin
            cmd(getc[s], SUCCESS_CODE);
            for (int w = 0; w < 18; w++) begin
                apb(1'b0, ADDR_POOL + 12'(4 * w), 32'h0);
                chk(rv, pw(s, w));
            end
        end
        blank();
        for (int s = 0; s < 4; s++) begin
            for (int k = 0; k < 3; k++) disp(s, pos[k], 1'b1);
        end
        // An unmapped address must answer with an error and read as zero.
        apb(1'b0, 12'h080, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        chk(rv, 32'h0);
        complete_run();
    end
endmodule // oltc_top_tb
